// ===== verilog/phymcs_pkg.sv
/*
  Shared types and constants for the PHY management control and status block.
  Assumes a single 40 MHz system clock; management frames arrive on sampled pins.
*/
`default_nettype none

package phymcs_pkg;

  // ---------------------------------------------------------------------------
  // Register layouts
  // ---------------------------------------------------------------------------

  // Control register, most significant field first
  typedef struct packed {
    logic       soft_reset_bit;          // Self-clearing reset
    logic       loop_enable;             // Internal loop path
    logic       forced_speed_select;     // 1 = 100 Mb/s when forced and speed strap high
    logic       autoneg_enable;          // Negotiation on
    logic       low_power_enable;        // Power down both transceivers
    logic       isolate_enable;          // MII outputs released
    logic       autoneg_restart;         // Self-clearing restart
    logic       forced_duplex_select;    // 1 = full duplex when forced
    logic       collision_test_enable;   // Collision echoes transmit enable
    logic [6:0] reserved;                // Reads zero
  } phymcs_ctrl_type;

  // Status register, most significant field first
  typedef struct packed {
    logic       t4_ability;
    logic       fast_full_duplex_ability;
    logic       fast_half_duplex_ability;
    logic       slow_full_duplex_ability;
    logic       slow_half_duplex_ability;
    logic [3:0] reserved;
    logic       preamble_suppress_ok;
    logic       autoneg_complete;
    logic       remote_fault_latched;
    logic       autoneg_ability;
    logic       link_up_latched;
    logic       jabber_latched;
    logic       extended_regs_ability;
  } phymcs_status_type;

  // Pins from outside the clock domain, synchronised together
  typedef struct packed {
    logic mdc;
    logic mdio;
    logic speed_strap;
    logic duplex_strap;
    logic tx_en;
  } phymcs_pin_type;

  // Management frame sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HDR,
    ST_TA,
    ST_DATA
  } phymcs_state_type;

  // ---------------------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------------------
  localparam int unsigned           PIN_W            = $bits(phymcs_pin_type);
  localparam logic [15:0]           CTRL_RESET       = 16'h3000;   // Negotiation on, 100 Mb/s
  localparam logic [15:0]           ZERO_WORD        = 16'h0000;   // Unmapped register answer
  localparam logic [6:0]            CTRL_RSVD        = 7'h00;
  localparam logic [3:0]            STAT_RSVD        = 4'h0;
  localparam logic [4:0]            REG_CONTROL      = 5'h00;
  localparam logic [4:0]            REG_STATUS       = 5'h01;
  localparam logic [4:0]            DEFAULT_PHY_ADDR = 5'h01;      // Plain default
  localparam logic [1:0]            OP_READ          = 2'h2;
  localparam logic [1:0]            OP_WRITE         = 2'h1;
  localparam logic [3:0]            HDR_LAST         = 4'hB;       // Op, PHY and register bits
  localparam logic [3:0]            TA_LAST          = 4'h1;       // Two turnaround bits
  localparam logic [3:0]            DATA_LAST        = 4'hF;       // Sixteen data bits
  localparam logic                  ABLE_T4          = 1'b0;
  localparam logic                  ABLE_OTHER       = 1'b1;

endpackage : phymcs_pkg

`default_nettype wire

// ===== verilog/phymcs_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous pins.
  Assumes pins are quasi-static relative to the 40 MHz clock.
*/
`default_nettype none

module phymcs_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Pins in, synchronised copy out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // ---------------------------------------------------------------------------
  // Two flip-flop stages; first stage feeds only the second
  // ---------------------------------------------------------------------------
  logic [W-1:0] meta_q;   // First stage

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : phymcs_sync

`default_nettype wire

// ===== verilog/phymcs_regs.sv
/*
  Control and status registers of an embedded 10/100 PHY, reached by
  clause 22 management frames on MDC/MDIO. Assumes the PHY core drives
  link, jabber, fault and negotiation signals on clk_i; MDC, MDIO, straps
  and MII transmit enable are asynchronous and synchronised here.
*/
`default_nettype none

module phymcs_regs #(
  parameter logic [4:0] PHY_ADDR = phymcs_pkg::DEFAULT_PHY_ADDR
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Management pins
  input  wire logic mdc_i,
  input  wire logic mdio_i,
  output logic      mdio_o,
  output logic      mdio_oe_n_o,
  // Strap pins
  input  wire logic speed_strap_i,
  input  wire logic duplex_strap_input_i,
  // MII pins
  input  wire logic mii_transmit_enable_in_i,
  output logic      mii_collision_out_o,
  output logic      mii_collision_oe_n_o,
  // PHY core status
  input  wire logic link_ok_i,
  input  wire logic jabber_i,
  input  wire logic remote_fault_i,
  input  wire logic an_done_i,
  input  wire logic an_started_i,
  input  wire logic an_speed_100_i,
  input  wire logic an_full_duplex_i,
  // PHY core controls
  output logic      phy_soft_reset_o,
  output logic      tx_medium_en_o,
  output logic      rx_medium_en_o,
  output logic      loop_path_o,
  output logic      low_power_o,
  output logic      an_enable_o,
  output logic      an_start_o,
  output logic      speed_100_o,
  output logic      full_duplex_o
);

  // ---------------------------------------------------------------------------
  // Pin synchronisation and MDC edge
  // ---------------------------------------------------------------------------
  phymcs_pkg::phymcs_pin_type   pin_raw;          // Raw pins
  phymcs_pkg::phymcs_pin_type   pin_s;            // Synchronised pins
  logic                         mdc_prev_q;       // MDC one clock ago
  logic                         mdc_rise;         // MDC rising edge seen

  assign pin_raw = '{mdc: mdc_i, mdio: mdio_i, speed_strap: speed_strap_i,
                     duplex_strap: duplex_strap_input_i, tx_en: mii_transmit_enable_in_i};

  phymcs_sync #(
    .W (phymcs_pkg::PIN_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (pin_raw),
    .q_o     (pin_s)
  );

  // Edge detector on the synchronised clock
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mdc_prev_q <= 1'b0;
    else
      mdc_prev_q <= pin_s.mdc;
  end

  assign mdc_rise = pin_s.mdc & ~mdc_prev_q;

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  phymcs_pkg::phymcs_state_type state_q;          // Frame sequencer
  logic [3:0]                   cnt_q;            // Bit count in phase
  logic                         prev_bit_q;       // Last idle bit, for start
  logic [11:0]                  hdr_q;            // Op, PHY address, register
  logic [15:0]                  shift_q;          // Data shifter
  logic                         mdio_q;           // Driven MDIO level
  logic                         mdio_oe_n_q;      // Low while driving
  phymcs_pkg::phymcs_ctrl_type  ctrl_q;           // Control register
  phymcs_pkg::phymcs_ctrl_type  ctrl_wr;          // Control write value
  phymcs_pkg::phymcs_status_type status_word;     // Assembled status
  logic                         rf_q;             // Remote fault latch
  logic                         link_q;           // Latched-low link
  logic                         jab_q;            // Jabber latch
  logic                         done_q;           // Negotiation complete
  logic                         powerup_q;        // Start owed since reset
  logic                         speed_q;          // Effective speed
  logic                         duplex_q;         // Effective duplex

  // ---------------------------------------------------------------------------
  // Frame decode
  // ---------------------------------------------------------------------------
  wire       hdr_read  = (hdr_q[11:10] == phymcs_pkg::OP_READ);
  wire       hdr_write = (hdr_q[11:10] == phymcs_pkg::OP_WRITE);
  wire       hdr_match = (hdr_q[9:5] == PHY_ADDR);
  wire [4:0] hdr_reg   = hdr_q[4:0];
  wire       sel_ctrl  = (hdr_reg == phymcs_pkg::REG_CONTROL);
  wire       sel_stat  = (hdr_reg == phymcs_pkg::REG_STATUS);
  wire       rd_go     = mdc_rise && (state_q == phymcs_pkg::ST_TA) && (cnt_q == '0)
                         && hdr_read && hdr_match;
  wire       rd_status = rd_go && sel_stat;
  wire [15:0] wr_word  = {shift_q[14:0], pin_s.mdio};
  wire       wr_ctrl   = mdc_rise && (state_q == phymcs_pkg::ST_DATA)
                         && (cnt_q == phymcs_pkg::DATA_LAST) && hdr_write && hdr_match && sel_ctrl;
  phymcs_pkg::phymcs_ctrl_type wr_fields;                         // Write word by field
  assign wr_fields = phymcs_pkg::phymcs_ctrl_type'(wr_word);
  wire       soft_rst  = wr_ctrl && wr_fields.soft_reset_bit;
  wire       restart_wr = wr_ctrl && !wr_fields.soft_reset_bit && wr_fields.autoneg_restart;
  wire [15:0] rd_word  = sel_ctrl ? ctrl_q : (sel_stat ? status_word : phymcs_pkg::ZERO_WORD);

  // ---------------------------------------------------------------------------
  // Management frame sequencer, runs regardless of power-down
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q     <= phymcs_pkg::ST_IDLE;
      cnt_q       <= '0;
      prev_bit_q  <= 1'b1;
      hdr_q       <= '0;
      shift_q     <= '0;
      mdio_q      <= 1'b1;
      mdio_oe_n_q <= 1'b1;
    end
    else if (mdc_rise)
    begin
      unique case (state_q)
        // Start is 0 then 1; preamble not required
        phymcs_pkg::ST_IDLE:
        begin
          prev_bit_q <= pin_s.mdio;
          if (!prev_bit_q && pin_s.mdio)
          begin
            state_q <= phymcs_pkg::ST_HDR;
            cnt_q   <= '0;
          end
        end
        // Collect op, address and register number
        phymcs_pkg::ST_HDR:
        begin
          hdr_q <= {hdr_q[10:0], pin_s.mdio};
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == phymcs_pkg::HDR_LAST)
          begin
            state_q <= phymcs_pkg::ST_TA;
            cnt_q   <= '0;
          end
        end
        // Turnaround: drive 0 on second bit when reading
        phymcs_pkg::ST_TA:
        begin
          cnt_q <= cnt_q + 4'h1;
          if (rd_go)
          begin
            mdio_oe_n_q <= 1'b0;
            mdio_q      <= 1'b0;
            shift_q     <= rd_word;
          end
          if (cnt_q == phymcs_pkg::TA_LAST)
          begin
            state_q <= phymcs_pkg::ST_DATA;
            cnt_q   <= '0;
            if (!mdio_oe_n_q)
              mdio_q <= shift_q[15];
          end
        end
        // Sixteen data bits, out or in
        phymcs_pkg::ST_DATA:
        begin
          cnt_q <= cnt_q + 4'h1;
          if (!mdio_oe_n_q)
          begin
            shift_q <= {shift_q[14:0], 1'b0};
            mdio_q  <= shift_q[14];
          end
          else
            shift_q <= wr_word;
          if (cnt_q == phymcs_pkg::DATA_LAST)
          begin
            state_q     <= phymcs_pkg::ST_IDLE;
            prev_bit_q  <= 1'b1;
            mdio_q      <= 1'b1;
            mdio_oe_n_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------

  // Write value with self-clearing and reserved bits forced
  always_comb
  begin
    ctrl_wr                 = phymcs_pkg::phymcs_ctrl_type'(wr_word);
    ctrl_wr.soft_reset_bit  = 1'b0;
    ctrl_wr.reserved        = phymcs_pkg::CTRL_RSVD;
    ctrl_wr.autoneg_restart = wr_fields.autoneg_restart | (ctrl_q.autoneg_restart & ~an_started_i);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctrl_q <= phymcs_pkg::CTRL_RESET;
    else if (soft_rst)
      ctrl_q <= phymcs_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= ctrl_wr;
    else if (an_started_i)
      ctrl_q.autoneg_restart <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Status latches; a read reloads from the live condition
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rf_q      <= 1'b0;
      link_q    <= 1'b0;
      jab_q     <= 1'b0;
      done_q    <= 1'b0;
      powerup_q <= 1'b1;
    end
    else if (soft_rst)
    begin
      rf_q      <= 1'b0;
      link_q    <= 1'b0;
      jab_q     <= 1'b0;
      done_q    <= 1'b0;
      powerup_q <= 1'b1;
    end
    else
    begin
      rf_q      <= rd_status ? remote_fault_i : (rf_q | remote_fault_i);
      link_q    <= rd_status ? link_ok_i : (link_q & link_ok_i);
      jab_q     <= rd_status ? jabber_i : (jab_q | jabber_i);
      done_q    <= restart_wr ? 1'b0 : (an_done_i & ~an_start_o);
      powerup_q <= powerup_q & ~an_started_i;
    end
  end

  // Status word assembly
  always_comb
  begin
    status_word                          = '0;
    status_word.t4_ability               = phymcs_pkg::ABLE_T4;
    status_word.fast_full_duplex_ability = phymcs_pkg::ABLE_OTHER;
    status_word.fast_half_duplex_ability = phymcs_pkg::ABLE_OTHER;
    status_word.slow_full_duplex_ability = phymcs_pkg::ABLE_OTHER;
    status_word.slow_half_duplex_ability = phymcs_pkg::ABLE_OTHER;
    status_word.reserved                 = phymcs_pkg::STAT_RSVD;
    status_word.preamble_suppress_ok     = phymcs_pkg::ABLE_OTHER;
    status_word.autoneg_complete         = done_q;
    status_word.remote_fault_latched     = rf_q;
    status_word.autoneg_ability          = phymcs_pkg::ABLE_OTHER;
    status_word.link_up_latched          = link_q;
    status_word.jabber_latched           = jab_q;
    status_word.extended_regs_ability    = phymcs_pkg::ABLE_OTHER;
  end

  // ---------------------------------------------------------------------------
  // Effective speed and duplex
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      speed_q  <= 1'b0;
      duplex_q <= 1'b0;
    end
    else
    begin
      speed_q  <= ctrl_q.autoneg_enable ? an_speed_100_i
                  : (ctrl_q.forced_speed_select & pin_s.speed_strap);
      duplex_q <= ctrl_q.autoneg_enable ? an_full_duplex_i
                  : (ctrl_q.forced_duplex_select | pin_s.duplex_strap);
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign mdio_o               = mdio_q;
  assign mdio_oe_n_o          = mdio_oe_n_q;
  assign mii_collision_out_o  = ctrl_q.collision_test_enable & pin_s.tx_en;
  assign mii_collision_oe_n_o = ctrl_q.isolate_enable;
  assign phy_soft_reset_o     = soft_rst;
  assign tx_medium_en_o       = ~ctrl_q.loop_enable;
  assign rx_medium_en_o       = ~ctrl_q.loop_enable;
  assign loop_path_o          = ctrl_q.loop_enable;
  assign low_power_o          = ctrl_q.low_power_enable;
  assign an_enable_o          = ctrl_q.autoneg_enable;
  assign an_start_o           = ctrl_q.autoneg_restart | powerup_q;
  assign speed_100_o          = speed_q;
  assign full_duplex_o        = duplex_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_SOFT_RESET_DEFAULT: assert property (soft_rst |=> (ctrl_q == phymcs_pkg::CTRL_RESET) && !done_q)
    else $error("Soft reset did not restore control defaults");
  AST_LOOP_BLOCKS_MEDIUM: assert property (ctrl_q.loop_enable |-> !tx_medium_en_o && !rx_medium_en_o && loop_path_o)
    else $error("Loop mode left the medium path open");
  AST_SPEED_FORCED: assert property (!ctrl_q.autoneg_enable |=> speed_100_o == $past(ctrl_q.forced_speed_select & pin_s.speed_strap))
    else $error("Forced speed is not register and strap");
  AST_DUPLEX_FORCED: assert property (!ctrl_q.autoneg_enable |=> full_duplex_o == $past(ctrl_q.forced_duplex_select | pin_s.duplex_strap))
    else $error("Forced duplex is not register or strap");
  AST_COLLISION_TEST: assert property (ctrl_q.collision_test_enable && pin_s.tx_en |-> mii_collision_out_o)
    else $error("Collision test did not echo transmit enable");
  AST_ISOLATE: assert property (ctrl_q.isolate_enable |-> mii_collision_oe_n_o)
    else $error("MII output driven while isolated");
  AST_RESERVED_ZERO: assert property (ctrl_q.reserved == '0 && status_word.reserved == '0)
    else $error("Reserved bits not zero");
  AST_RESTART_CLEARS_DONE: assert property (restart_wr |=> !done_q && an_start_o)
    else $error("Restart did not clear complete or request start");
  AST_LINK_LATCH_LOW: assert property (!link_ok_i && !rd_status |=> !link_q ##1 (!link_q || $past(rd_status)))
    else $error("Link failure not held until read");
  AST_FAULT_HOLD: assert property (rf_q && !rd_status && !soft_rst |=> rf_q)
    else $error("Remote fault dropped without a read");
  AST_JABBER_HOLD: assert property (jab_q && jabber_i && !soft_rst |=> jab_q)
    else $error("Jabber cleared while condition persists");
  AST_ABILITY_FIXED: assert property (status_word[15:11] == 5'h0F && status_word[3] && status_word[0])
    else $error("Ability bits changed");

  COV_STATUS_READ: cover property (rd_status ##[1:400] (mdio_oe_n_q == 1'b1));
  COV_CTRL_WRITE: cover property (wr_ctrl && !soft_rst);
  COV_SOFT_RESET: cover property (soft_rst);

endmodule : phymcs_regs

`default_nettype wire

// ===== sim/phymcs_sta.sv
/*
  Station manager model: clause 22 read and write frames on MDC/MDIO.
  Assumes the bench resolves the shared MDIO wire with a pull-up.
*/
`default_nettype none

module phymcs_sta (
  // Management pins
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      drv_o,
  output logic      dat_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: MDC stands low, line released
  initial
  begin
    mdc_o = 1'b0;
    drv_o = 1'b0;
    dat_o = 1'b1;
  end

  // One frame, MSB first, 200 ns bit time
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [35:0] f;
    f = {4'hF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 35; i >= 0; i--)
    begin
      drv_o = (op == phymcs_pkg::OP_WRITE) || (i > 17);
      dat_o = f[i];
      #100 mdc_o = 1'b1;
      if (i < 16)
        rd = {rd[14:0], mdio_i};
      #100 mdc_o = 1'b0;
    end
    drv_o = 1'b0;
  endtask : xfer
endmodule : phymcs_sta

`default_nettype wire

// ===== sim/tb_phy_mgmt_control_status.sv
/*
  Self-checking bench for the PHY control and status registers.
  Assumes phymcs_regs and the station manager model phymcs_sta.
*/
`default_nettype none

module tb_phy_mgmt_control_status;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] PA = phymcs_pkg::DEFAULT_PHY_ADDR;
  localparam logic [4:0] RC = phymcs_pkg::REG_CONTROL;
  localparam logic [4:0] RS = phymcs_pkg::REG_STATUS;
  logic clk_i, rst_n_i, mdc_i, mdio_o, mdio_oe_n_o, speed_strap_i, duplex_strap_input_i, drv, dat;
  logic mii_transmit_enable_in_i, mii_collision_out_o, mii_collision_oe_n_o, link_ok_i, jabber_i;
  logic remote_fault_i, an_done_i, an_started_i, an_speed_100_i, an_full_duplex_i, phy_soft_reset_o;
  logic tx_medium_en_o, rx_medium_en_o, loop_path_o, low_power_o, an_enable_o, an_start_o;
  logic speed_100_o, full_duplex_o;
  logic [31:0] seed = 32'hd52f;
  logic [31:0] v;
  logic [15:0] ctl, rd;
  int errors, checks;
  logic [15:0] sr_cnt = 16'h0000;
  // Pulled-up MDIO wire
  wire logic mdio_i = !mdio_oe_n_o ? mdio_o : (drv ? dat : 1'b1);

  phymcs_regs uut (.*);
  phymcs_sta sta (.mdio_i(mdio_i), .mdc_o(mdc_i), .drv_o(drv), .dat_o(dat));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Core acknowledges a start one cycle later
  always @(posedge clk_i)
    an_started_i <= #1 an_start_o;

  // Count soft reset pulses seen by the core
  always @(posedge clk_i)
    if (phy_soft_reset_o === 1'b1)
      sr_cnt <= sr_cnt + 16'h0001;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Frame, then let the update settle
  task automatic xf(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                    input logic [15:0] wd, output logic [15:0] r);
    @(posedge clk_i);
    #1 sta.xfer(op, pa, ra, wd, r);
    repeat (6) @(posedge clk_i);
    #1;
  endtask : xf

  task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] r;
    xf(phymcs_pkg::OP_WRITE, pa, ra, wd, r);
  endtask : wr

  task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] r;
    xf(phymcs_pkg::OP_READ, PA, ra, 16'h0000, r);
    chk(r, exp);
  endtask : rdc

  task automatic stop_test();
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // Watchdog
  initial
  begin
    #1_000_000;
    errors++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    {rst_n_i, speed_strap_i, duplex_strap_input_i, mii_transmit_enable_in_i, jabber_i} = 5'h08;
    {link_ok_i, remote_fault_i, an_done_i, an_speed_100_i, an_full_duplex_i} = 5'h10;
    errors = 0;
    checks = 0;
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    xf(phymcs_pkg::OP_READ, PA, RS, 16'h0000, rd);
    rdc(RC, 16'h3000);
    rdc(RS, 16'h784D);
    {remote_fault_i, link_ok_i, jabber_i, an_done_i} = 4'hB;
    @(posedge clk_i);
    #1 {remote_fault_i, link_ok_i} = 2'b01;
    rdc(RS, 16'h787B);
    rdc(RS, 16'h786F);
    jabber_i = 1'b0;
    rdc(RS, 16'h786F);
    rdc(RS, 16'h786D);
    wr(PA, RC, 16'h1200);
    rdc(RC, 16'h1000);
    for (int k = 0; k < 6; k++)
    begin
      v = rnd();
      {speed_strap_i, duplex_strap_input_i, an_speed_100_i, an_full_duplex_i} = v[19:16];
      mii_transmit_enable_in_i = v[20];
      ctl = v[15:0] & 16'h7FFF;
      wr(PA, RC, ctl);
      ctl = ctl & 16'hFD80;
      rdc(RC, ctl);
      chk({7'h00, loop_path_o, tx_medium_en_o, rx_medium_en_o, low_power_o, an_enable_o,
           mii_collision_oe_n_o, mii_collision_out_o, speed_100_o, full_duplex_o},
          {7'h00, ctl[14], !ctl[14], !ctl[14], ctl[11], ctl[12], ctl[10], ctl[7] & v[20],
           ctl[12] ? v[17] : ctl[13] & v[19], ctl[12] ? v[16] : ctl[8] | v[18]});
    end
    wr(PA, RC, 16'h8000);
    rdc(RC, 16'h3000);
    chk(sr_cnt, 16'h0001);
    wr(5'h02, RC, 16'h0000);
    wr(PA, 5'h03, 16'hFFFF);
    rdc(RC, 16'h3000);
    rdc(5'h03, 16'h0000);
    stop_test();
  end
endmodule : tb_phy_mgmt_control_status

`default_nettype wire
